// ---- rtl/can_msg_buf_ctrl.sv ----
// message buffer flags, control bytes and dma ram buffer writer
//----------------------------------------------------------------------
// Contract
// - receive sets full flag, software clears it
// - store into full buffer sets overflow
// - control word holds two buffer bytes
// - direction bit one transmit, zero receive
// - abort, arbitration lost, bus error read-only
// - buffer words live in dma ram
// - id word: sid 12-2, srr, ide
// - eid 17-6 in 11-0, top zero
// - eid 5-0 in 15-10, dlc 3-0
// - bit 9 marks remote request
// - length code in low four bits
// - eight data bytes two per word
// - filter hit code in status 12-8
// - hit code only for receive buffers
// - thirty-two buffers indexed from zero
// - per-filter four-bit buffer pointer
//----------------------------------------------------------------------
`timescale 1ns/100ps
module can_msg_buf_ctrl
   import can_buf_pkg::*;
#(
   parameter int RAM_AW = 10
) (
   input wire logic clk, // 50 MHz clock
   input wire logic reset, // synchronous, active high
   input wire logic [ADDR_W-1:0] reg_addr, // register word index
   input wire logic [15:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [15:0] reg_rdata, // read data, cycle after strobe
   input wire logic rx_valid, // accepted message pulse from protocol
   input wire logic [3:0] rx_filter, // filter that accepted it
   input wire logic [10:0] rx_sid, // standard identifier
   input wire logic [17:0] rx_eid, // extended identifier
   input wire logic rx_ide, // extended format
   input wire logic rx_srr, // substitute remote
   input wire logic rx_rtr, // remote request
   input wire logic [3:0] rx_dlc, // data length code
   input wire logic [63:0] rx_data, // bytes, byte 0 in low bits
   input wire logic tx_done, // send outcome pulse from protocol
   input wire logic [4:0] tx_buf, // buffer the outcome refers to
   input wire logic tx_ok, // sent successfully
   input wire logic tx_abort, // aborted
   input wire logic tx_arb_lost, // lost arbitration
   input wire logic tx_bus_err, // bus error seen
   output logic ram_we, // dma ram write strobe
   output logic [RAM_AW-1:0] ram_addr, // dma ram word address
   output logic [15:0] ram_wdata, // dma ram write data
   output logic [NUM_BUF-1:0] send_pending, // send request per buffer
   output logic irq // level interrupt
);
   //-------------------------------------------------------------------
   // state
   //-------------------------------------------------------------------
   typedef enum {ST_IDLE, ST_STORE} wr_state_t;
   typedef struct packed {
      logic [NUM_BUF-1:0] full;
      logic [NUM_BUF-1:0] ovf;
      logic [NUM_BUF-1:0][7:0] ctrl;
      logic [NUM_FILT-1:0][3:0] ptr;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
      logic [15:0] rdata;
      logic irq;
      logic we;
      logic [RAM_AW-1:0] addr;
      logic [15:0] wdata;
      logic [2:0] widx;
      logic [4:0] wbuf;
      logic [4:0] whit;
      logic [15:0][0:0] pad; // sixteen spare bits, never read or written
      logic [7:0][15:0] msg; // captured words of the message
   } state_t;
   state_t s_r, s_nxt;
   wr_state_t st_r, st_nxt;

   // dma ram layout: each buffer takes eight words
   logic [4:0] dest;
   logic [4:0] ovf_idx;
   logic [15:0] rd_val;
   logic [3:0] ev;
   logic [NUM_BUF-1:0] full_clr, ovf_clr;
   logic [NUM_BUF-1:0] ctrl_wr;

   assign dest = {1'b0, s_r.ptr[rx_filter]};

   //-------------------------------------------------------------------
   // write-side decodes: zero-to-clear on the full and overflow words
   //-------------------------------------------------------------------
   always_comb begin
      full_clr = '0;
      ovf_clr = '0;
      ctrl_wr = '0;
      if (reg_wr) begin
         if (reg_addr == OFS_FULL_LO) full_clr[15:0] = ~reg_wdata;
         if (reg_addr == OFS_FULL_HI) full_clr[31:16] = ~reg_wdata;
         if (reg_addr == OFS_OVF_LO) ovf_clr[15:0] = ~reg_wdata;
         if (reg_addr == OFS_OVF_HI) ovf_clr[31:16] = ~reg_wdata;
         if (reg_addr[7:4] == OFS_CTRL_BASE[7:4]) begin
            ctrl_wr[{reg_addr[3:0], 1'b0}] = 1'b1;
            ctrl_wr[{reg_addr[3:0], 1'b1}] = 1'b1;
         end
      end
   end

   //-------------------------------------------------------------------
   // read mux, answered one cycle after the strobe
   //-------------------------------------------------------------------
   always_comb begin
      rd_val = RST_16;
      case (reg_addr)
         OFS_FULL_LO: rd_val = s_r.full[15:0];
         OFS_FULL_HI: rd_val = s_r.full[31:16];
         OFS_OVF_LO: rd_val = s_r.ovf[15:0];
         OFS_OVF_HI: rd_val = s_r.ovf[31:16];
         OFS_IRQ_STAT: rd_val = {12'h000, s_r.irq_stat};
         OFS_IRQ_MASK: rd_val = {12'h000, s_r.irq_mask};
         default: begin
            if (reg_addr[7:2] == OFS_PTR_BASE[7:2])
               rd_val = {s_r.ptr[{reg_addr[1:0], 2'h3}],
                         s_r.ptr[{reg_addr[1:0], 2'h2}],
                         s_r.ptr[{reg_addr[1:0], 2'h1}],
                         s_r.ptr[{reg_addr[1:0], 2'h0}]};
            else if (reg_addr[7:4] == OFS_CTRL_BASE[7:4])
               rd_val = {s_r.ctrl[{reg_addr[3:0], 1'b1}],
                         s_r.ctrl[{reg_addr[3:0], 1'b0}]};
         end
      endcase
   end

   //-------------------------------------------------------------------
   // next state
   //-------------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      st_nxt = st_r;
      ev = '0;
      ovf_idx = dest;
      s_nxt.rdata = reg_rd ? rd_val : RST_16;
      s_nxt.we = 1'b0;
      // software clears first so a same-cycle hardware set wins
      s_nxt.full = s_r.full & ~full_clr;
      s_nxt.ovf = s_r.ovf & ~ovf_clr;
      for (int i = 0; i < NUM_BUF; i++) begin
         if (ctrl_wr[i]) begin
            s_nxt.ctrl[i] = (s_r.ctrl[i] & ~CB_WR_MASK)
               | (reg_wdata[(i%2)*8 +: 8] & CB_WR_MASK);
         end
      end
      if (reg_wr && reg_addr[7:2] == OFS_PTR_BASE[7:2]) begin
         for (int k = 0; k < 4; k++)
            s_nxt.ptr[{reg_addr[1:0], 2'(k)}] = reg_wdata[k*4 +: 4];
      end
      if (reg_wr && reg_addr == OFS_IRQ_MASK)
         s_nxt.irq_mask = reg_wdata[3:0];
      if (reg_wr && reg_addr == OFS_IRQ_STAT)
         s_nxt.irq_stat = s_r.irq_stat & ~reg_wdata[3:0];
      // transmit outcome from the protocol engine
      if (tx_done && s_r.ctrl[tx_buf][CB_DIR]) begin
         s_nxt.ctrl[tx_buf][CB_ABT] = tx_abort;
         s_nxt.ctrl[tx_buf][CB_LARB] = tx_arb_lost;
         s_nxt.ctrl[tx_buf][CB_ERR] = tx_bus_err;
         if (tx_ok) begin
            s_nxt.ctrl[tx_buf][CB_REQ] = 1'b0;
            ev[IRQ_TXDONE] = 1'b1;
         end else begin
            ev[IRQ_TXFAIL] = 1'b1;
         end
      end
      case (st_r)
         ST_IDLE: begin
            // a message to a transmit buffer is dropped, nothing stored
            if (rx_valid && !s_r.ctrl[dest][CB_DIR]) begin
               if (s_r.full[dest]) begin
                  s_nxt.ovf[ovf_idx] = 1'b1;
                  ev[IRQ_OVF] = 1'b1;
               end
               s_nxt.wbuf = dest;
               s_nxt.whit = {1'b0, rx_filter};
               s_nxt.widx = W_SID;
               s_nxt.msg[0] = {3'h0, rx_sid, rx_srr, rx_ide};
               s_nxt.msg[1] = {4'h0, rx_eid[17:6]};
               s_nxt.msg[2] = {rx_eid[5:0], rx_rtr, 1'b0, 3'h0,
                               1'b0, rx_dlc};
               for (int b = 0; b < 4; b++)
                  s_nxt.msg[3+b] = rx_data[b*16 +: 16];
               s_nxt.msg[7] = {3'h0, 5'(rx_filter), 8'h00};
               st_nxt = ST_STORE;
            end
         end
         ST_STORE: begin
            s_nxt.we = 1'b1;
            s_nxt.addr = RAM_AW'({s_r.wbuf, s_r.widx});
            s_nxt.wdata = s_r.msg[s_r.widx];
            s_nxt.widx = s_r.widx + 3'h1;
            if (s_r.widx == W_STAT) begin
               s_nxt.full[s_r.wbuf] = 1'b1;
               ev[IRQ_RX] = 1'b1;
               st_nxt = ST_IDLE;
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
      s_nxt.irq_stat = s_nxt.irq_stat | ev;
      s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
   end

   //-------------------------------------------------------------------
   // registers
   //-------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         s_r <= '0; // all flags cleared at reset
         st_r <= ST_IDLE;
      end else begin
         s_r <= s_nxt;
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state flops
   assign reg_rdata = s_r.rdata;
   assign ram_we = s_r.we;
   assign ram_addr = s_r.addr;
   assign ram_wdata = s_r.wdata;
   assign irq = s_r.irq;
   generate
      for (genvar g = 0; g < NUM_BUF; g++) begin : g_req
         assign send_pending[g] = s_r.ctrl[g][CB_REQ];
      end
   endgenerate
endmodule // can_msg_buf_ctrl

// ---- rtl/can_buf_pkg.sv ----
// shared constants for the message buffer control block
package can_buf_pkg;
   localparam int NUM_BUF = 32;
   localparam int NUM_FILT = 16;
   localparam int ADDR_W = 8;
   // register offsets (word index on the plain register port)
   localparam logic [7:0] OFS_FULL_LO = 8'h00;
   localparam logic [7:0] OFS_FULL_HI = 8'h01;
   localparam logic [7:0] OFS_OVF_LO = 8'h02;
   localparam logic [7:0] OFS_OVF_HI = 8'h03;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h05;
   localparam logic [7:0] OFS_PTR_BASE = 8'h08; // four pointer words
   localparam logic [7:0] OFS_CTRL_BASE = 8'h10; // sixteen pair words
   // control byte field positions
   localparam int CB_DIR = 7;
   localparam int CB_ABT = 6;
   localparam int CB_LARB = 5;
   localparam int CB_ERR = 4;
   localparam int CB_REQ = 3;
   localparam int CB_RTREN = 2;
   localparam int CB_PRI_HI = 1;
   localparam int CB_PRI_LO = 0;
   localparam logic [7:0] CB_WR_MASK = 8'h8f; // software-writable bits
   // buffer words in dma ram: word index inside a buffer
   localparam logic [2:0] W_SID = 3'h0;
   localparam logic [2:0] W_EID = 3'h1;
   localparam logic [2:0] W_DLC = 3'h2;
   localparam logic [2:0] W_STAT = 3'h7;
   localparam int SID_LSB = 2;
   localparam int SRR_BIT = 1;
   localparam int IDE_BIT = 0;
   localparam int EID_HI_LSB = 0;
   localparam int EID_LO_LSB = 10;
   localparam int RTR_BIT = 9;
   localparam int RB1_BIT = 8;
   localparam int RB0_BIT = 4;
   localparam int FILTER_HIT_CODE_LSB = 8;
   localparam logic [15:0] RST_16 = 16'h0000;
   // interrupt status bit positions
   localparam int IRQ_RX = 0;
   localparam int IRQ_OVF = 1;
   localparam int IRQ_TXDONE = 2;
   localparam int IRQ_TXFAIL = 3;
endpackage

// ---- dv/dma_ram_model.sv ----
// dma ram model holding every word the block stores
`timescale 1ns/100ps
module dma_ram_model #(
   parameter int AW = 10
) (
   input wire logic clk, // clock
   input wire logic we, // write strobe
   input wire logic [AW-1:0] addr, // word address
   input wire logic [15:0] wdata // write data
);
   logic [15:0] mem [2**AW];
   int writes = 0; // stored word count
   // no wait states: a real dma port never stalls this block either
   always @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
         writes <= writes + 1;
      end
   end
endmodule // dma_ram_model

// ---- dv/can_buf_chk.sv ----
// port assertions for the message buffer control block
`timescale 1ns/100ps
module can_buf_chk
   import can_buf_pkg::*;
#(
   parameter int RAM_AW = 10
) (
   input wire logic clk, // clock
   input wire logic reset, // sync reset
   input wire logic reg_rd, // read strobe
   input wire logic reg_wr, // write strobe
   input wire logic [15:0] reg_rdata, // read data
   input wire logic rx_valid, // message pulse
   input wire logic tx_done, // outcome pulse
   input wire logic ram_we, // ram strobe
   input wire logic [RAM_AW-1:0] ram_addr, // ram address
   input wire logic [15:0] ram_wdata, // ram data
   input wire logic [NUM_BUF-1:0] send_pending // send requests
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // ----
   // store burst shape and word layout
   // ----
   burst_len_a: assert property ($rose(ram_we) |-> ram_we[*8] ##1 !ram_we)
      else $error("store burst not eight words");
   burst_start_a: assert property ($rose(ram_we) |->
      $past(rx_valid, 2) && ram_addr[2:0] == W_SID)
      else $error("store burst start wrong");
   addr_step_a: assert property (ram_we && $past(ram_we) |->
      ram_addr == RAM_AW'($past(ram_addr) + 1'b1))
      else $error("store address did not step");
   sid_word_a: assert property (ram_we && ram_addr[2:0] == W_SID |->
      ram_wdata[15:13] == 3'h0)
      else $error("id word top bits set");
   eid_word_a: assert property (ram_we && ram_addr[2:0] == W_EID |->
      ram_wdata[15:12] == 4'h0)
      else $error("extended id word top bits set");
   dlc_word_a: assert property (ram_we && ram_addr[2:0] == W_DLC |->
      ram_wdata[7:5] == 3'h0)
      else $error("length word bits 7-5 set");
   stat_word_a: assert property (ram_we && ram_addr[2:0] == W_STAT |->
      ram_wdata[15:13] == 3'h0 && ram_wdata[7:0] == 8'h00)
      else $error("status word unused bits set");
   // read data only in the cycle after a strobe
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside its cycle");
   pend_cause_a: assert property (send_pending != $past(send_pending) |->
      $past(reg_wr) || $past(tx_done))
      else $error("send request changed on its own");
endmodule // can_buf_chk
bind can_msg_buf_ctrl can_buf_chk #(.RAM_AW(RAM_AW)) chk_u (.clk, .reset,
   .reg_rd, .reg_wr, .reg_rdata, .rx_valid, .tx_done, .ram_we, .ram_addr,
   .ram_wdata, .send_pending);

// ---- dv/tb_can_message_buffer_control.sv ----
// register level bench for the message buffer control block
`timescale 1ns/100ps
module tb_can_message_buffer_control;
   logic clk = '0, reset = 1'h1, reg_wr = '0, reg_rd = '0, rx_valid = '0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, ram_wdata, rd_v;
   logic [3:0] rx_filter = 4'h0, rx_dlc = 4'h8;
   logic [10:0] rx_sid = 11'h000;
   logic [17:0] rx_eid = 18'h2a5c3;
   logic rx_ide = 1'h1, rx_srr = '0, rx_rtr = 1'h1, tx_done = '0, tx_ok = '0;
   logic tx_abort = '0, tx_arb_lost = '0, tx_bus_err = '0, ram_we, irq;
   logic irq_s, irq_a;
   logic [63:0] rx_data = 64'h8877665544332211;
   logic [4:0] tx_buf = 5'h00;
   logic [9:0] ram_addr;
   logic [31:0] send_pending, pend_s;
   logic [15:0] ew [8];
   int miscompares = 0, cmp_count = 0, n;
   always #10 clk = ~clk;
   // levels sampled mid-cycle so edge updates have landed
   always @(negedge clk) begin
      irq_s = irq;
      pend_s = send_pending;
   end
   can_msg_buf_ctrl #(.RAM_AW(10)) dut_u (.*);
   dma_ram_model #(.AW(10)) ram_u (.clk(clk), .we(ram_we), .addr(ram_addr),
      .wdata(ram_wdata));
   // ----
   // bus tasks
   // ----
   task automatic chk(input string nm, input logic [63:0] e, g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   // trailing edge keeps strobe drives one per time step
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= '0;
      @(posedge clk);
   endtask
   task automatic rc(input string nm, input logic [7:0] a, logic [15:0] e);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= '0;
      #1 rd_v = reg_rdata;
      @(posedge clk);
      chk(nm, e, rd_v);
   endtask
   // spacing of eleven cycles keeps receptions legal
   task automatic rx(input logic [3:0] f);
      rx_filter <= f;
      rx_sid <= 11'h5a3;
      rx_valid <= 1'h1;
      @(posedge clk);
      rx_valid <= '0;
      repeat (11) @(posedge clk);
   endtask
   task automatic tx(input logic ok, arb);
      tx_buf <= 5'h01;
      tx_ok <= ok;
      tx_arb_lost <= arb;
      tx_done <= 1'h1;
      @(posedge clk);
      tx_done <= '0;
      repeat (2) @(posedge clk);
   endtask
   task automatic results;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ----
   // scenarios
   // ----
   initial begin
      ew = '{{3'h0, 11'h5a3, 1'h0, 1'h1}, {4'h0, rx_eid[17:6]},
         {rx_eid[5:0], 1'h1, 1'h0, 3'h0, 1'h0, 4'h8}, 16'h2211, 16'h4433,
         16'h6655, 16'h8877, {3'h0, 5'h03, 8'h00}};
      repeat (10) @(posedge clk);
      reset <= '0;
      @(posedge clk);
      rc("full_hi", 8'h01, 16'h0000);
      rc("ovf_hi", 8'h03, 16'h0000);
      rc("unmapped", 8'h06, 16'h0000);
      wr(8'h11, 16'h7000);
      rc("ctrl_ro", 8'h11, 16'h0000);
      wr(8'h08, 16'h5000);
      rc("pointer", 8'h08, 16'h5000);
      rx(4'h3);
      for (int w = 0; w < 8; w++) chk("ram", ew[w], ram_u.mem[40+w]);
      rc("full_lo", 8'h00, 16'h0020);
      rc("irq_stat", 8'h04, 16'h0001);
      wr(8'h05, 16'h0000);
      @(posedge clk);
      irq_a = irq_s;
      wr(8'h05, 16'h000f);
      @(posedge clk);
      chk("irq_mask", 1'h1, irq_a ^ irq_s);
      wr(8'h04, 16'h000f);
      @(posedge clk);
      chk("irq_clr", 1'h0, irq_s);
      rx(4'h3);
      rc("ovf_lo", 8'h02, 16'h0020);
      wr(8'h02, 16'hffdf);
      rc("ovf_clr", 8'h02, 16'h0000);
      wr(8'h00, 16'hffdf);
      rc("full_clr", 8'h00, 16'h0000);
      wr(8'h10, 16'h8800);
      chk("pending", 32'h2, pend_s);
      tx('0, 1'h1);
      rc("arb_lost", 8'h10, 16'ha800);
      tx(1'h1, '0);
      chk("sent", 32'h0, pend_s);
      wr(8'h08, 16'h0001);
      n = ram_u.writes;
      rx(4'h0);
      chk("tx_drop", n, ram_u.writes);
      rc("full_drop", 8'h00, 16'h0000);
      results();
   end
endmodule // tb_can_message_buffer_control
